// ### rtl/sfp_consts.vh
// Purpose: Constants for the serial flash mode and status protection block
// Assumes: 40 MHz ref_clk; the link pins are sampled, never used as clocks
// Notes:   Every code, bit position, non-volatile default and timing count lives here
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// ==========================================================================
// Command codes
`define SFP_CMD_WREN      8'h06
`define SFP_CMD_WRDI      8'h04
`define SFP_CMD_RDSR_LO   8'h05
`define SFP_CMD_RDSR_HI   8'h35
`define SFP_CMD_WRSR_LO   8'h01
`define SFP_CMD_WRSR_HI   8'h31
`define SFP_CMD_PROG      8'h02
`define SFP_CMD_PROG_Q    8'h32
`define SFP_CMD_RD_Q_OUT  8'h6B
`define SFP_CMD_RD_Q_IO   8'hEB
`define SFP_CMD_ERASE_4K  8'h20
`define SFP_CMD_ERASE_32K 8'h52
`define SFP_CMD_ERASE_64K 8'hD8
`define SFP_CMD_ERASE_C1  8'h60
`define SFP_CMD_ERASE_C2  8'hC7
`define SFP_CMD_SEC_WR    8'h2F
`define SFP_CMD_QUAD_IN   8'h38
`define SFP_CMD_QUAD_OUT  8'hFF
`define SFP_CMD_SUSPEND   8'h75
`define SFP_CMD_RESUME    8'h7A
`define SFP_CMD_DPD       8'hB9
`define SFP_CMD_DPD_REL   8'hAB
`define SFP_CMD_RST_EN    8'h66
`define SFP_CMD_RST       8'h99

// ==========================================================================
// Status bit positions (low byte S7..S0, high byte S15..S8)
`define SFP_LO_BUSY       0
`define SFP_LO_WPL        1
`define SFP_LO_GUARD_LO   7
`define SFP_HI_GUARD_HI   0
`define SFP_HI_QLE        1
`define SFP_HI_SUSP       7

// ==========================================================================
// Non-volatile defaults loaded by the factory-load strap, and the guard codes
`define SFP_QLE_DEFAULT   1'b1
`define SFP_GUARD_DEFAULT 2'b00
`define SFP_GUARD_PCYCLE  2'b10
`define SFP_GUARD_OTP     2'b11
`define SFP_GUARD_HW      2'b01

// ==========================================================================
// Timing: times in ns, cycle counts derived from the clock period
`define SFP_CLK_NS        25
`define SFP_PUW_NS        1000
`define SFP_PUW_CYC       ((`SFP_PUW_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_OP_NS         5000
`define SFP_OP_CYC        ((`SFP_OP_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_CNT_W         12

`endif

// ### rtl/sfp_sync.v
// Purpose: Two-stage synchroniser for the link pins
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none

module sfp_sync #(
    parameter       W     = 6,
    parameter [5:0] RST_V = 6'h00
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         rst_n,
    // Pins in, synchronised out
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta_q;

    // ======================================================================
    // First stage feeds the second stage only
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q   <= RST_V[W-1:0];
            sync_out <= RST_V[W-1:0];
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ### rtl/sfp_top.v
// Purpose: Mode selection, write gating and status registers of a serial flash
// Assumes: rst_n low means power is off; link pins sampled by ref_clk
// Notes:   Array, data reads and electrical timing are outside this block
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.vh"

module sfp_top (
    // Clock and power-on reset
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       nv_factory_load,
    // Link pins
    input  wire       cs_pin_n,
    input  wire       sck_pin,
    input  wire [3:0] lane_in,
    output reg  [3:0] lane_out,
    output reg  [3:0] lane_oe,
    // Observed state
    output reg  [7:0] status_low_byte,
    output reg  [7:0] status_high_byte,
    output reg        four_lane_command_mode,
    output reg        lanes_as_data_q,
    output reg        power_down_q
);

    // ======================================================================
    // Decode helpers
    function sfp_is_change;
        input [7:0] c;
        begin
            sfp_is_change = (c == `SFP_CMD_WREN)      || (c == `SFP_CMD_PROG) ||
                            (c == `SFP_CMD_PROG_Q)    || (c == `SFP_CMD_SEC_WR) ||
                            (c == `SFP_CMD_WRSR_LO)   || (c == `SFP_CMD_WRSR_HI) ||
                            (c == `SFP_CMD_ERASE_4K)  || (c == `SFP_CMD_ERASE_32K) ||
                            (c == `SFP_CMD_ERASE_64K) || (c == `SFP_CMD_ERASE_C1) ||
                            (c == `SFP_CMD_ERASE_C2);
        end
    endfunction

    function sfp_is_quad;
        input [7:0] c;
        begin
            sfp_is_quad = (c == `SFP_CMD_PROG_Q) || (c == `SFP_CMD_RD_Q_OUT) ||
                          (c == `SFP_CMD_RD_Q_IO);
        end
    endfunction

    function sfp_is_long_op;
        input [7:0] c;
        begin
            sfp_is_long_op = sfp_is_change(c) && (c != `SFP_CMD_WREN) &&
                             (c != `SFP_CMD_WRSR_LO) && (c != `SFP_CMD_WRSR_HI);
        end
    endfunction

    // Admission of a command given the present device state
    function sfp_gate;
        input [7:0] c;
        input       dpd;
        input       busy;
        input       locked;
        input       qle;
        begin
            if (dpd)
                sfp_gate = (c == `SFP_CMD_DPD_REL);
            else if (busy)
                sfp_gate = (c == `SFP_CMD_RDSR_LO) || (c == `SFP_CMD_RDSR_HI) ||
                           (c == `SFP_CMD_SUSPEND);
            else if (locked && sfp_is_change(c))
                sfp_gate = 1'b0;
            else if (sfp_is_quad(c) && !qle)
                sfp_gate = 1'b0;
            else
                sfp_gate = 1'b1;
        end
    endfunction

    // ======================================================================
    // Pin synchronisers and edge detection
    wire [5:0] pins_s;
    reg        sck_prev_q;
    reg        cs_prev_q;

    sfp_sync #(
        .W     (6),
        .RST_V (6'h20)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({cs_pin_n, sck_pin, lane_in}),
        .sync_out (pins_s)
    );

    wire       cs_n_s  = pins_s[5];
    wire       sck_s   = pins_s[4];
    wire [3:0] lanes_s = pins_s[3:0];
    wire       sck_rise = sck_s & ~sck_prev_q;
    wire       sck_fall = ~sck_s & sck_prev_q;
    wire       cs_fall  = cs_prev_q & ~cs_n_s;
    wire       cs_rise  = ~cs_prev_q & cs_n_s;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    // ======================================================================
    // State
    reg [7:0]            shift_q;
    reg [2:0]            bit_cnt_q;
    reg [2:0]            byte_cnt_q;
    reg [7:0]            cmd_q;
    reg [7:0]            data1_q;
    reg [7:0]            data2_q;
    reg [7:0]            out_sr_q;
    reg                  read_on_q;
    reg                  wpl_q;
    reg                  busy_q;
    reg                  susp_q;
    reg                  qle_q;
    reg [1:0]            guard_q;
    reg                  rst_arm_q;
    reg [`SFP_CNT_W-1:0] lock_cnt_q;
    reg [`SFP_CNT_W-1:0] op_cnt_q;

    // Timer loads cut to the counter width on purpose
    localparam [31:0] LOCK_LOAD = `SFP_PUW_CYC;
    localparam [31:0] OP_LOAD   = `SFP_OP_CYC;

    wire       locked   = (lock_cnt_q != {`SFP_CNT_W{1'b0}});
    wire       four     = four_lane_command_mode;
    // Hold pin pauses shifting only when its pin role is active
    wire       hold_ok  = four || qle_q || lanes_s[3];
    wire [7:0] sh_next  = four ? {shift_q[3:0], lanes_s} : {shift_q[6:0], lanes_s[0]};
    wire       byte_end = four ? (bit_cnt_q == 3'h4) : (bit_cnt_q == 3'h7);
    wire [2:0] bit_step = four ? 3'h4 : 3'h1;
    wire       whole    = (bit_cnt_q == 3'h0);
    wire       cmd_ok   = (byte_cnt_q != 3'h0) &&
                          sfp_gate(cmd_q, power_down_q, busy_q, locked, qle_q);
    wire       new_ok   = sfp_gate(sh_next, power_down_q, busy_q, locked, qle_q);
    // Write-protect pin acts whenever quad enable is clear, even in four-lane mode
    wire       wp_high  = qle_q || lanes_s[2];
    wire       sr_ok    = wpl_q &&
                          (guard_q != `SFP_GUARD_OTP) &&
                          (guard_q != `SFP_GUARD_PCYCLE) &&
                          !((guard_q == `SFP_GUARD_HW) && !wp_high);

    // ======================================================================
    // Main control: reset, timers, frame capture and command execution
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            // Nothing is recognised while reset holds
            shift_q    <= 8'h00;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
            cmd_q      <= 8'h00;
            data1_q    <= 8'h00;
            data2_q    <= 8'h00;
            out_sr_q   <= 8'h00;
            read_on_q  <= 1'b0;
            wpl_q      <= 1'b0;
            busy_q     <= 1'b0;
            susp_q     <= 1'b0;
            rst_arm_q  <= 1'b0;
            four_lane_command_mode <= 1'b0;
            power_down_q <= 1'b0;
            lane_out   <= 4'h0;
            lane_oe    <= 4'h0;
            lock_cnt_q <= LOCK_LOAD[`SFP_CNT_W-1:0];
            op_cnt_q   <= {`SFP_CNT_W{1'b0}};
            // Non-volatile bits survive a power cycle with factory load low, except lock-down
            if (nv_factory_load) begin
                qle_q   <= `SFP_QLE_DEFAULT;
                guard_q <= `SFP_GUARD_DEFAULT;
            end else if (guard_q == `SFP_GUARD_PCYCLE) begin
                guard_q <= `SFP_GUARD_DEFAULT;
            end
        end else begin
            if (locked)
                lock_cnt_q <= lock_cnt_q - 1'b1;

            // Operation timer; completion drops busy and the latch
            if (busy_q) begin
                if (op_cnt_q == {{(`SFP_CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_q <= 1'b0;
                    wpl_q  <= 1'b0;
                end
                op_cnt_q <= op_cnt_q - 1'b1;
            end

            if (cs_fall) begin
                // A new frame always starts at select fall
                bit_cnt_q  <= 3'h0;
                byte_cnt_q <= 3'h0;
                read_on_q  <= 1'b0;
                lane_oe    <= 4'h0;
            end else if (!cs_n_s && sck_rise && hold_ok) begin
                // Rising edge sampling, most significant bit first
                shift_q   <= sh_next;
                bit_cnt_q <= bit_cnt_q + bit_step;
                if (byte_end) begin
                    if (byte_cnt_q != 3'h7)
                        byte_cnt_q <= byte_cnt_q + 3'h1;
                    if (byte_cnt_q == 3'h0) begin
                        cmd_q <= sh_next;
                        if (new_ok && ((sh_next == `SFP_CMD_RDSR_LO) ||
                                       (sh_next == `SFP_CMD_RDSR_HI))) begin
                            read_on_q <= 1'b1;
                            out_sr_q  <= (sh_next == `SFP_CMD_RDSR_LO) ?
                                         status_low_byte : status_high_byte;
                        end
                    end
                    if (byte_cnt_q == 3'h1)
                        data1_q <= sh_next;
                    if (byte_cnt_q == 3'h2)
                        data2_q <= sh_next;
                end
            end else if (!cs_n_s && sck_fall && read_on_q) begin
                // Status byte repeats while select stays low
                if (four) begin
                    lane_out <= out_sr_q[7:4];
                    lane_oe  <= 4'hF;
                    out_sr_q <= {out_sr_q[3:0], out_sr_q[7:4]};
                end else begin
                    lane_out <= {2'b00, out_sr_q[7], 1'b0};
                    lane_oe  <= 4'h2;
                    out_sr_q <= {out_sr_q[6:0], out_sr_q[7]};
                end
            end else if (cs_rise) begin
                read_on_q <= 1'b0;
                lane_oe   <= 4'h0;
                if (cmd_ok) begin
                    rst_arm_q <= 1'b0;
                    case (cmd_q)
                        `SFP_CMD_WREN: begin
                            wpl_q <= 1'b1;
                        end
                        `SFP_CMD_WRDI: begin
                            wpl_q <= 1'b0;
                        end
                        `SFP_CMD_WRSR_LO: begin
                            // Refused writes change nothing but the software reset arm
                            if (whole && sr_ok && byte_cnt_q >= 3'h2) begin
                                guard_q[0] <= data1_q[`SFP_LO_GUARD_LO];
                                if (byte_cnt_q >= 3'h3) begin
                                    guard_q[1] <= data2_q[`SFP_HI_GUARD_HI];
                                    qle_q      <= data2_q[`SFP_HI_QLE];
                                end
                                busy_q   <= 1'b1;
                                op_cnt_q <= OP_LOAD[`SFP_CNT_W-1:0];
                            end
                        end
                        `SFP_CMD_WRSR_HI: begin
                            if (whole && sr_ok && byte_cnt_q >= 3'h2) begin
                                guard_q[1] <= data1_q[`SFP_HI_GUARD_HI];
                                qle_q      <= data1_q[`SFP_HI_QLE];
                                busy_q     <= 1'b1;
                                op_cnt_q   <= OP_LOAD[`SFP_CNT_W-1:0];
                            end
                        end
                        `SFP_CMD_QUAD_IN: begin
                            if (qle_q)
                                four_lane_command_mode <= 1'b1;
                        end
                        `SFP_CMD_QUAD_OUT: begin
                            four_lane_command_mode <= 1'b0;
                        end
                        `SFP_CMD_SUSPEND: begin
                            if (busy_q) begin
                                susp_q <= 1'b1;
                                busy_q <= 1'b0;
                            end
                        end
                        `SFP_CMD_RESUME: begin
                            if (susp_q) begin
                                susp_q <= 1'b0;
                                // A suspend on the last count left nothing to run
                                busy_q <= (op_cnt_q != {`SFP_CNT_W{1'b0}});
                            end
                        end
                        `SFP_CMD_DPD: begin
                            power_down_q <= 1'b1;
                        end
                        `SFP_CMD_DPD_REL: begin
                            power_down_q <= 1'b0;
                        end
                        `SFP_CMD_RST_EN: begin
                            rst_arm_q <= 1'b1;
                        end
                        `SFP_CMD_RST: begin
                            // Software reset aborts suspended work and leaves four-lane mode
                            if (rst_arm_q) begin
                                four_lane_command_mode <= 1'b0;
                                wpl_q  <= 1'b0;
                                busy_q <= 1'b0;
                                susp_q <= 1'b0;
                            end
                        end
                        default: begin
                            // Array-changing work needs latch and whole bytes
                            if (sfp_is_long_op(cmd_q) && whole && wpl_q) begin
                                busy_q   <= 1'b1;
                                op_cnt_q <= OP_LOAD[`SFP_CNT_W-1:0];
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ======================================================================
    // Registered views of status and lane roles
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            status_low_byte  <= 8'h00;
            status_high_byte <= 8'h00;
            lanes_as_data_q  <= 1'b0;
        end else begin
            // Reserved positions stay zero
            status_low_byte  <= {guard_q[0], 5'h00, wpl_q, busy_q};
            status_high_byte <= {susp_q, 5'h00, qle_q, guard_q[1]};
            lanes_as_data_q  <= four || qle_q;
        end
    end

endmodule

`default_nettype wire

// ### verif/sfp_monitor.sv
// Purpose: Port-level checks of the mode and status protection block
// Assumes: One ref_clk domain with a synchronous active-low reset
// Notes:   Bound to sfp_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.vh"

module sfp_monitor (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Link pins
    input wire logic       cs_pin_n,
    input wire logic [3:0] lane_in,
    input wire logic [3:0] lane_oe,
    // Observed state
    input wire logic [7:0] status_low_byte,
    input wire logic [7:0] status_high_byte,
    input wire logic       four_lane_command_mode,
    input wire logic       power_down_q
);
    // ==========
    // Status fields under short names
    wire       busy = status_low_byte[`SFP_LO_BUSY];
    wire       wpl  = status_low_byte[`SFP_LO_WPL];
    wire       qle  = status_high_byte[`SFP_HI_QLE];
    wire       susp = status_high_byte[`SFP_HI_SUSP];
    wire       fl   = four_lane_command_mode;
    wire       pd   = power_down_q;
    wire [1:0] grd  = {status_high_byte[`SFP_HI_GUARD_HI], status_low_byte[`SFP_LO_GUARD_LO]};

    // ==========
    // Checks, all muted while power is off
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_reserved_zero: assert property ((status_low_byte[6:2] | status_high_byte[6:2]) == 5'h00)
        else $error("reserved status bit set");
    chk_busy_hold: assert property ($rose(busy) |=> busy [*8])
        else $error("busy dropped right after rising");
    chk_busy_latch: assert property ($fell(busy) |=> susp || !wpl)
        else $error("latch kept after operation end");
    chk_frame_end: assert property ($rose(wpl) || $changed(fl) || $changed(pd) |-> cs_pin_n)
        else $error("state changed inside a frame");
    chk_lane_dir: assert property (lane_oe != 4'h0 |-> lane_oe == (fl ? 4'hF : 4'h2))
        else $error("wrong lanes driven");
    chk_oe_idle: assert property (cs_pin_n [*6] |-> lane_oe == 4'h0)
        else $error("lanes driven while deselected");
    chk_guard_otp: assert property (grd == 2'b11 |=> grd == 2'b11 && $stable(qle))
        else $error("permanent guard changed");
    chk_guard_locked: assert property (grd == 2'b10 |=> grd == 2'b10 && $stable(qle))
        else $error("locked guard changed");
    chk_wp_refuse: assert property (grd == 2'b01 && !qle && !lane_in[2] |=> $stable({grd, qle}))
        else $error("status write passed a low protect pin");
    chk_latch_gate: assert property ($rose(wpl) |-> !$past(busy) && !$past(pd))
        else $error("latch set while busy or powered down");
endmodule

bind sfp_top sfp_monitor mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_pin_n(cs_pin_n), .lane_in(lane_in),
    .lane_oe(lane_oe), .status_low_byte(status_low_byte), .status_high_byte(status_high_byte),
    .four_lane_command_mode(four_lane_command_mode), .power_down_q(power_down_q)
);

`default_nettype wire

// ### verif/sfp_host.sv
// Purpose: Host controller model that drives the link pins
// Assumes: Mode 0 link clock of 200 ns, held low outside frames
// Notes:   Released lanes flip every cycle so stale values never pass
`timescale 1ns/1ps
`default_nettype none

module sfp_host (
    // Clock
    input  wire logic       ref_clk,
    // Link pins
    output var  logic       cs_pin_n,
    output var  logic       sck_pin,
    output wire logic [3:0] lane_in,
    input  wire logic [3:0] lane_out,
    input  wire logic [3:0] lane_oe
);
    // ==========
    // Lane drive state
    logic [3:0] hv       = 4'h0;
    logic [3:0] hoe      = 4'hC;
    logic [3:0] prev     = 4'h0;
    logic       quad     = 1'b0;
    logic       wp_lvl   = 1'b1;
    logic       hold_lvl = 1'b1;
    wire  [3:0] drv      = quad ? hv : {hold_lvl, wp_lvl, hv[1:0]};

    // Host wins, then the device, else the lane flips each cycle
    assign lane_in = (hoe & drv) | (~hoe & lane_oe & lane_out) | (~hoe & ~lane_oe & ~prev);
    always @(posedge ref_clk) prev <= lane_in;
    initial begin
        cs_pin_n = 1'b1;
        sck_pin  = 1'b0;
    end

    // One frame: select falls, n bits top first, select rises, idle gap
    task automatic frame(input logic [23:0] d, input integer n, input logic q,
                         output logic [7:0] rd);
        integer i;
        rd = 8'h00;
        quad = q;
        @(negedge ref_clk) cs_pin_n = 1'b0;
        for (i = 0; i < n; i = i + (q ? 4 : 1)) begin
            hoe = q ? ((i < 8) ? 4'hF : 4'h0) : 4'hD;
            hv  = q ? d[23 - i -: 4] : {3'h0, d[23 - i]};
            repeat (4) @(negedge ref_clk);
            sck_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
            rd = q ? {rd[3:0], lane_in} : {rd[6:0], lane_in[1]};
            sck_pin = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        cs_pin_n = 1'b1;
        hoe = 4'hC;
        quad = 1'b0;
        repeat (12) @(negedge ref_clk);
    endtask
endmodule

`default_nettype wire

// ### verif/sfp_top_tb.sv
// Purpose: Self-checking bench for mode selection and status protection
// Assumes: 25 ns ref_clk; the host model makes the 200 ns link clock
// Notes:   Early write lockout is too short to reach with a whole frame
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.vh"

module sfp_top_tb;
    // ==========
    // Clock, reset and wiring
    logic       ref_clk     = 1'b0;
    logic       rst_n       = 1'b0;
    logic       nv_load     = 1'b1;
    logic [7:0] rd;
    integer     fail_count  = 0;
    integer     check_count = 0;
    wire        cs_n, sck, fl, pd, lad;
    wire  [3:0] l_in, l_out, l_oe;
    wire  [7:0] lo, hi;

    // Free-running 40 MHz clock
    initial forever #12.5 ref_clk = ~ref_clk;

    sfp_top dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .nv_factory_load(nv_load), .cs_pin_n(cs_n),
        .sck_pin(sck), .lane_in(l_in), .lane_out(l_out), .lane_oe(l_oe),
        .status_low_byte(lo), .status_high_byte(hi), .four_lane_command_mode(fl),
        .lanes_as_data_q(lad), .power_down_q(pd)
    );
    sfp_host host (
        .ref_clk(ref_clk), .cs_pin_n(cs_n), .sck_pin(sck),
        .lane_in(l_in), .lane_out(l_out), .lane_oe(l_oe)
    );

    // ==========
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input logic [23:0] d, input integer n, input logic q);
        host.frame(d, n, q, rd);
    endtask
    // Write enable first, then the frame itself
    task automatic wr(input logic [23:0] d, input integer n);
        cmd(24'h060000, 8, 1'b0);
        cmd(d, n, 1'b0);
    endtask
    // Bounded wait for the busy flag to fall
    task automatic wait_idle;
        integer k;
        for (k = 0; k < 400 && lo[`SFP_LO_BUSY] !== 1'b0; k = k + 1)
            @(negedge ref_clk);
        if (k == 400) begin
            fail_count = fail_count + 1;
            results;
        end
    endtask
    // Power cycle; load high restores the factory settings
    task automatic power(input logic load);
        @(negedge ref_clk);
        rst_n = 1'b0;
        nv_load = load;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        nv_load = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    // ==========
    // Main sequence
    initial begin
        power(1'b1);
        check({hi, lo}, 16'h0200);
        check({14'h0, fl, pd}, 16'h0000);
        check({15'h0, lad}, 16'h0001);
        cmd(24'h060000, 8, 1'b0);
        check({hi, lo}, 16'h0202);
        host.frame(24'h050000, 16, 1'b0, rd);
        check({8'h00, rd}, 16'h0002);
        cmd(24'h040000, 8, 1'b0);
        check({hi, lo}, 16'h0200);
        wr(24'h018000, 12);
        check({hi, lo}, 16'h0202);
        $display("test latch done");
        cmd(24'h017C7C, 24, 1'b0);
        check({hi, lo}, 16'h0003);
        check({15'h0, lad}, 16'h0000);
        cmd(24'h040000, 8, 1'b0);
        check({hi, lo}, 16'h0003);
        cmd(24'h750000, 8, 1'b0);
        check({hi, lo}, 16'h8002);
        cmd(24'h7A0000, 8, 1'b0);
        check({hi, lo}, 16'h0003);
        wait_idle;
        check({hi, lo}, 16'h0000);
        // Quad program with quad enable clear must not start
        wr(24'h320000, 8);
        check({hi, lo}, 16'h0002);
        $display("test busy done");
        host.wp_lvl = 1'b0;
        wr(24'h018000, 24);
        wait_idle;
        check({hi, lo}, 16'h0080);
        wr(24'h310200, 16);
        check({hi, lo}, 16'h0082);
        host.wp_lvl = 1'b1;
        cmd(24'h010003, 24, 1'b0);
        wait_idle;
        check({hi, lo}, 16'h0300);
        wr(24'h018001, 24);
        check({hi, lo}, 16'h0302);
        power(1'b0);
        check({hi, lo}, 16'h0200);
        $display("test guards done");
        cmd(24'h380000, 8, 1'b0);
        cmd(24'h060000, 8, 1'b1);
        host.frame(24'h050000, 16, 1'b1, rd);
        check({7'h00, fl, rd}, 16'h0102);
        cmd(24'hFF0000, 8, 1'b1);
        check({15'h0, fl}, 16'h0000);
        cmd(24'h380000, 8, 1'b0);
        cmd(24'h660000, 8, 1'b1);
        cmd(24'h990000, 8, 1'b1);
        check({7'h00, fl, lo}, 16'h0000);
        $display("test modes done");
        cmd(24'hB90000, 8, 1'b0);
        cmd(24'h060000, 8, 1'b0);
        check({7'h00, pd, lo}, 16'h0100);
        cmd(24'hAB0000, 8, 1'b0);
        check({15'h0, pd}, 16'h0000);
        $display("test power-down done");
        wr(24'h018003, 24);
        wait_idle;
        wr(24'h010000, 24);
        check({hi, lo}, 16'h0382);
        power(1'b0);
        check({hi, lo}, 16'h0380);
        $display("test permanent guard done");
        results;
    end
endmodule

`default_nettype wire
